// file: design/sbct_wide_timer.sv
// Sixteen-bit down counter/timer with transmit, demodulation, ping-pong
//
// Function
// R1: Disabled in normal or ping-pong mode, output is inverse of initial level.
// R2: Output-force field 10 or 11 forces output low or high, always.
// R3: Enabling loads counter from both reload bytes, output takes initial level.
// R4: Reaching zero toggles output, sets timeout flag, raises enabled interrupt.
// R5: One-shot mode stops the counter after it reaches zero.
// R6: Auto-reload mode reloads both reload bytes on zero and keeps counting.
// R7: Reload bytes writable any time; counter sees them at next load.
// R8: Count of zero wraps to FFFF and continues; wrap is no timeout.
// R9: Software never programs an initial count of one.
// R10: Software sets both reload bytes to FF before demodulation.
// R11: Demodulation: first selected edge captures, reloads and starts counting.
// R12: Sub-mode 0: later edges capture complemented count, reload FFFF, restart.
// R13: Each capture sets its edge flag and raises enabled capture interrupt.
// R14: Software stops both timers, sets one-shot and ping-pong, then enables.
// R15: Stopping then restarting reloads the initial value.
// R16: Ping-pong hardware starts one timer when the other finishes.
// R17: In ping-pong, each terminal count sets that timer's timeout flag.
// R18: Narrow output drives port 3 bit 4, wide output drives bit 5.
// R19: Shared control bit 6 routes a selected logic combination to bit 6.
// R20: Registers sit in bank D, chosen by register pointer low nibble.
// R21: Counter drops by one per enabled tick and holds while disabled.
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module sbct_wide_timer
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] registerPointer,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  input  wire logic       timerTick,
  input  wire logic       pulseIn,
  input  wire logic       narrowTimerOutput,
  input  wire logic       narrowTimeout,
  input  wire logic       narrowPinEnable,
  output logic            narrowStart,
  output logic            timeoutIrq,
  output logic            captureIrq,
  output logic            port3Bit4Pin,
  output logic            port3Bit4Drive,
  output logic            port3Bit5Pin,
  output logic            port3Bit5Drive,
  output logic            port3Bit6Pin,
  output logic            port3Bit6Drive
);

  ////////////////////////////////////////////////////////////////////////////
  // Register access decode
  function automatic logic regHit(input logic       strobe,
                                  input logic [3:0] ptrBank,
                                  input logic [3:0] addr,
                                  input logic [3:0] offset);
    regHit = strobe && (ptrBank == sbct_pkg::BANK_SEL) && (addr == offset);
  endfunction : regHit

  sbct_pkg::sbct_state_t state;
  sbct_pkg::sbct_state_t next_state;
  logic [15:0] count;
  logic [15:0] capture;
  logic [7:0]  reloadLo;
  logic [7:0]  reloadHi;
  logic        initLevel;
  logic        demodSel;
  logic        combEn;
  logic [1:0]  selField;
  logic [1:0]  outMode;
  logic [1:0]  edgeFlags;
  logic        modeBit;
  logic        toFlag;
  logic        capIe;
  logic        toIe;
  logic        pinEn;
  logic        wideOut;
  logic        pulsePrev;

  // Strobes per register (see R20)
  wire logic [3:0] ptrBank = registerPointer[3:0];
  wire logic wrCtrl1 = regHit(regWrite, ptrBank, regAddr, sbct_pkg::OFF_CTRL1);
  wire logic wrCtrl2 = regHit(regWrite, ptrBank, regAddr, sbct_pkg::OFF_CTRL2);
  wire logic wrRldLo = regHit(regWrite, ptrBank, regAddr, sbct_pkg::OFF_RLD_LO);
  wire logic wrRldHi = regHit(regWrite, ptrBank, regAddr, sbct_pkg::OFF_RLD_HI);
  wire logic bankOk  = (ptrBank == sbct_pkg::BANK_SEL);

  ////////////////////////////////////////////////////////////////////////////
  // Event decode
  wire logic [15:0] reloadValue = {reloadHi, reloadLo};
  wire logic pingPong  = (outMode == sbct_pkg::OUT_PINGPONG) && !demodSel;
  wire logic isIdle    = (state == sbct_pkg::ST_IDLE);
  wire logic counting  = (state == sbct_pkg::ST_COUNT);
  wire logic swEnable  = wrCtrl2 && regWrData[sbct_pkg::C2_ENABLE];
  wire logic swStop    = wrCtrl2 && !regWrData[sbct_pkg::C2_ENABLE];
  wire logic swStart   = swEnable && isIdle;
  wire logic hwStart   = pingPong && narrowTimeout && isIdle; // see R16
  wire logic startEvt  = swStart || hwStart;                  // see R16
  wire logic tickCount = counting && timerTick;               // see R21
  wire logic reachZero = tickCount && (count == sbct_pkg::COUNT_ONE);
  wire logic wrapZero  = tickCount && (count == sbct_pkg::COUNT_ZERO);
  wire logic stopZero  = reachZero && !modeBit;               // see R5
  wire logic toggleOk  = !demodSel && !outMode[1];

  // Input edge qualification
  wire logic riseEdge  = pulseIn && !pulsePrev;
  wire logic fallEdge  = !pulseIn && pulsePrev;
  wire logic riseQual  = demodSel && selField[0] && riseEdge;
  wire logic fallQual  = demodSel && selField[1] && fallEdge;
  wire logic qualEdge  = riseQual || fallQual;
  wire logic armedSt   = (state == sbct_pkg::ST_ARMED);
  wire logic firstEdge = armedSt && qualEdge;                 // see R11
  wire logic laterEdge = counting && qualEdge;
  wire logic captureEvt = firstEdge || laterEdge;

  ////////////////////////////////////////////////////////////////////////////
  // State sequencing
  always_comb
  begin
    next_state = state;
    unique case (state)
      sbct_pkg::ST_IDLE:
      begin
        if (startEvt)
          next_state = demodSel ? sbct_pkg::ST_ARMED : sbct_pkg::ST_COUNT;
      end
      sbct_pkg::ST_ARMED:
      begin
        if (swStop)
          next_state = sbct_pkg::ST_IDLE;
        else if (firstEdge)
          next_state = sbct_pkg::ST_COUNT;
      end
      sbct_pkg::ST_COUNT:
      begin
        if (swStop || stopZero)
          next_state = sbct_pkg::ST_IDLE;
      end
    endcase
  end

  // Counter next value
  wire logic [15:0] countDec = count - sbct_pkg::COUNT_ONE;
  wire logic [15:0] zeroLoad = modeBit ? reloadValue : sbct_pkg::COUNT_ZERO;
  wire logic [15:0] next_count =
    startEvt               ? reloadValue :                // see R3, R15
    firstEdge              ? reloadValue :                // see R10
    (laterEdge && !modeBit) ? sbct_pkg::DEMOD_RELOAD :     // see R12
    reachZero              ? zeroLoad :                   // see R6
    wrapZero               ? sbct_pkg::COUNT_WRAP :       // see R8
    tickCount              ? countDec : count;            // see R21

  // Output level and flags
  wire logic next_wideOut = startEvt ? initLevel :          // see R3
                            (reachZero && toggleOk) ? !wideOut : // see R4
                            wideOut;
  wire logic toClear   = wrCtrl2 && regWrData[sbct_pkg::C2_TOFLAG];
  wire logic next_toFlag = reachZero ? 1'b1 :              // see R4, R17
                           toClear ? 1'b0 : toFlag;
  wire logic edgeClrEn = wrCtrl1 && regWrData[sbct_pkg::C1_DEMOD];
  wire logic [1:0] edgeSet = captureEvt ? {fallQual, riseQual} : 2'h0;
  wire logic [1:0] edgeClr = edgeClrEn ? regWrData[1:0] : 2'h0;
  wire logic [1:0] next_edgeFlags = edgeSet | (edgeFlags & ~edgeClr); // see R13

  ////////////////////////////////////////////////////////////////////////////
  // Pin output selection
  wire logic idleLevel = isIdle && !demodSel;
  wire logic wideTimerOutput =
    (outMode == sbct_pkg::OUT_FORCE0) ? 1'b0 :             // see R2
    (outMode == sbct_pkg::OUT_FORCE1) ? 1'b1 :             // see R2
    idleLevel ? !initLevel : wideOut;                      // see R1
  wire logic combAnd = narrowTimerOutput & wideTimerOutput;
  wire logic combOr  = narrowTimerOutput | wideTimerOutput;
  wire logic combOut = (selField == sbct_pkg::COMB_AND) ? combAnd :
                       (selField == sbct_pkg::COMB_OR)  ? combOr :
                       (selField == sbct_pkg::COMB_NOR) ? !combOr : !combAnd;

  // Read data selection
  wire logic [1:0] lowBits = demodSel ? edgeFlags : {1'b0, initLevel};
  wire logic [7:0] ctrl1Rd = {demodSel, combEn, selField, outMode, lowBits};
  wire logic [7:0] ctrl2Rd = {!isIdle, modeBit, toFlag, 2'h0,
                              capIe, toIe, pinEn};
  wire logic [7:0] next_rdData =
    (!regRead || !bankOk)             ? sbct_pkg::BYTE_RESET :
    (regAddr == sbct_pkg::OFF_CTRL1)  ? ctrl1Rd :
    (regAddr == sbct_pkg::OFF_CTRL2)  ? ctrl2Rd :
    (regAddr == sbct_pkg::OFF_RLD_LO) ? reloadLo :
    (regAddr == sbct_pkg::OFF_RLD_HI) ? reloadHi :
    (regAddr == sbct_pkg::OFF_CAP_LO) ? capture[7:0] :
    (regAddr == sbct_pkg::OFF_CAP_HI) ? capture[15:8] :
    sbct_pkg::BYTE_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // Counter core registers
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state     <= sbct_pkg::ST_IDLE;
      count     <= sbct_pkg::COUNT_RESET;
      wideOut   <= 1'b0;
      toFlag    <= 1'b0;
      edgeFlags <= 2'h0;
      pulsePrev <= 1'b0;
    end
    else
    begin
      state     <= next_state;
      count     <= next_count;
      wideOut   <= next_wideOut;
      toFlag    <= next_toFlag;
      edgeFlags <= next_edgeFlags;
      pulsePrev <= pulseIn;
    end
  end

  // Capture register, complement of the running count
  always_ff @(posedge clk)
  begin
    if (srst)
      capture <= sbct_pkg::COUNT_RESET;
    else if (captureEvt)
      capture <= ~count;                                    // see R12
  end

  // Software control fields
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      reloadLo  <= sbct_pkg::BYTE_RESET;
      reloadHi  <= sbct_pkg::BYTE_RESET;
      initLevel <= 1'b0;
      demodSel  <= 1'b0;
      combEn    <= 1'b0;
      selField  <= 2'h0;
      outMode   <= sbct_pkg::OUT_NORMAL;
      modeBit   <= 1'b0;
      capIe     <= 1'b0;
      toIe      <= 1'b0;
      pinEn     <= 1'b0;
    end
    else
    begin
      if (wrRldLo)
        reloadLo <= regWrData;                              // see R7
      if (wrRldHi)
        reloadHi <= regWrData;                              // see R7
      if (wrCtrl1 && !regWrData[sbct_pkg::C1_DEMOD])
        initLevel <= regWrData[sbct_pkg::C1_INIT];
      if (wrCtrl1)
      begin
        demodSel <= regWrData[sbct_pkg::C1_DEMOD];
        combEn   <= regWrData[sbct_pkg::C1_COMBEN];
        selField <= regWrData[sbct_pkg::C1_SEL_LSB +: 2];
        outMode  <= regWrData[sbct_pkg::C1_OUT_LSB +: 2];
      end
      if (wrCtrl2)
      begin
        modeBit <= regWrData[sbct_pkg::C2_MODE];
        capIe   <= regWrData[sbct_pkg::C2_CAPIE];
        toIe    <= regWrData[sbct_pkg::C2_TOIE];
        pinEn   <= regWrData[sbct_pkg::C2_PINEN];
      end
    end
  end

  // Pins, pulses and read data
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      regRdData      <= sbct_pkg::BYTE_RESET;
      narrowStart    <= 1'b0;
      timeoutIrq     <= 1'b0;
      captureIrq     <= 1'b0;
      port3Bit4Pin   <= 1'b0;
      port3Bit4Drive <= 1'b0;
      port3Bit5Pin   <= 1'b0;
      port3Bit5Drive <= 1'b0;
      port3Bit6Pin   <= 1'b0;
      port3Bit6Drive <= 1'b0;
    end
    else
    begin
      regRdData      <= next_rdData;
      narrowStart    <= pingPong && stopZero;               // see R16
      timeoutIrq     <= reachZero && toIe;                  // see R4
      captureIrq     <= captureEvt && capIe;                // see R13
      port3Bit4Pin   <= narrowTimerOutput;                  // see R18
      port3Bit4Drive <= narrowPinEnable;                    // see R18
      port3Bit5Pin   <= wideTimerOutput;                    // see R18
      port3Bit5Drive <= pinEn;                              // see R18
      port3Bit6Pin   <= combOut;                            // see R19
      port3Bit6Drive <= combEn;                             // see R19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cbDef @(posedge clk);
  endclocking
  default disable iff (srst);

  a_idle_level: assert property (idleLevel && !outMode[1]        // see R1
    |=> port3Bit5Pin == !$past(initLevel))
    else $error("idle output is not the inverse of the initial level");

  a_force_out: assert property (outMode[1]                       // see R2
    |=> port3Bit5Pin == $past(outMode[0]))
    else $error("forced output level is wrong");

  a_start_load: assert property (startEvt                        // see R3
    |=> count == $past(reloadValue) && wideOut == $past(initLevel))
    else $error("start did not load count and initial level");

  a_zero_event: assert property (reachZero && toIe && toggleOk   // see R4
    |=> timeoutIrq && toFlag && wideOut != $past(wideOut))
    else $error("terminal count did not toggle, flag and interrupt");

  a_oneshot_stop: assert property (stopZero && !swEnable         // see R5
    |=> isIdle ##1 (isIdle || $past(startEvt)))
    else $error("one-shot timer kept running after zero");

  a_auto_reload: assert property (reachZero && modeBit && !swStop // see R6
    && !startEvt && !laterEdge |=> count == $past(reloadValue) && counting)
    else $error("auto-reload did not reload");

  a_zero_wrap: assert property (wrapZero && !startEvt        // see R8
    && !laterEdge |=> count == sbct_pkg::COUNT_WRAP && !timeoutIrq)
    else $error("zero count did not wrap quietly");

  a_edge_capture: assert property (laterEdge && !modeBit         // see R12
    && !startEvt |=> capture == ~$past(count)
    && count == sbct_pkg::DEMOD_RELOAD)
    else $error("later edge capture or reload wrong");

  a_capture_flag: assert property (captureEvt && capIe           // see R13
    |=> captureIrq && (edgeFlags != 2'h0))
    else $error("capture did not flag and interrupt");

  a_tick_dec: assert property (tickCount                     // see R21
    && count > sbct_pkg::COUNT_ONE && !startEvt && !captureEvt
    |=> count == $past(count) - 16'h0001)
    else $error("counter did not drop by one");

  a_hold_count: assert property (!tickCount && !startEvt     // see R21
    && !captureEvt |=> $stable(count))
    else $error("counter moved while not ticking");

  a_pingpong_hand: assert property (pingPong && stopZero         // see R16
    |=> narrowStart ##1 !narrowStart)
    else $error("ping-pong handover pulse missing");

  c_timeout: cover property (reachZero && toggleOk);
  c_capture: cover property (laterEdge ##[1:50] laterEdge);
  c_pingpong: cover property (narrowStart ##[1:100] hwStart);
  c_wrap: cover property (wrapZero);

endmodule : sbct_wide_timer

`default_nettype wire

// file: inc/sbct_pkg.sv
// Constants and types for the sixteen-bit counter/timer
`default_nettype none

package sbct_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bank and register offsets inside the selected bank
  localparam logic [3:0] BANK_SEL   = 4'hd;
  localparam logic [3:0] OFF_CTRL1  = 4'h1;
  localparam logic [3:0] OFF_CTRL2  = 4'h2;
  localparam logic [3:0] OFF_RLD_LO = 4'h6;
  localparam logic [3:0] OFF_RLD_HI = 4'h7;
  localparam logic [3:0] OFF_CAP_LO = 4'h8;
  localparam logic [3:0] OFF_CAP_HI = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Shared control field positions
  localparam int C1_DEMOD   = 7;
  localparam int C1_COMBEN  = 6;
  localparam int C1_SEL_LSB = 4;
  localparam int C1_OUT_LSB = 2;
  localparam int C1_INIT    = 0;
  localparam int C1_RISE    = 0;
  localparam int C1_FALL    = 1;

  // Wide timer control field positions
  localparam int C2_ENABLE = 7;
  localparam int C2_MODE   = 6;
  localparam int C2_TOFLAG = 5;
  localparam int C2_CAPIE  = 2;
  localparam int C2_TOIE   = 1;
  localparam int C2_PINEN  = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Output mode field codes
  localparam logic [1:0] OUT_NORMAL   = 2'h0;
  localparam logic [1:0] OUT_PINGPONG = 2'h1;
  localparam logic [1:0] OUT_FORCE0   = 2'h2;
  localparam logic [1:0] OUT_FORCE1   = 2'h3;

  // Logic combination codes for the shared pin
  localparam logic [1:0] COMB_AND  = 2'h0;
  localparam logic [1:0] COMB_OR   = 2'h1;
  localparam logic [1:0] COMB_NOR  = 2'h2;
  localparam logic [1:0] COMB_NAND = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and counter constants
  localparam logic [7:0]  BYTE_RESET   = 8'h00;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam logic [15:0] COUNT_ONE    = 16'h0001;
  localparam logic [15:0] COUNT_WRAP   = 16'hffff;
  localparam logic [15:0] DEMOD_RELOAD = 16'hffff;

  // Wide timer states
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_COUNT} sbct_state_t;

endpackage : sbct_pkg

`default_nettype wire

// file: tb/sbct_narrow_model.sv
// Behavioural companion narrow timer for ping-pong and pin tests
`timescale 1ns/100ps
`default_nettype none

module sbct_narrow_model
#(
  parameter int LEN = 6 // Initial count, never one
)
(
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic narrowStart,
  input  wire logic initLevel,
  input  wire logic pinEnReq,
  output logic      narrowTimerOutput,
  output logic      narrowTimeout,
  output logic      narrowPinEnable
);
  int   count;
  logic running;

  ////////////////////////////////////////////////////////////////////////////
  // One-shot count, started only by the wide timer
  always_ff @(posedge clk)
  begin
    narrowTimeout <= 1'b0;
    if (srst)
    begin
      running <= 1'b0;
      count   <= 0;
    end
    else if (narrowStart)
    begin
      running <= 1'b1;
      count   <= LEN;
    end
    else if (running && count == 1)
    begin
      running       <= 1'b0; // Stops and hands over
      narrowTimeout <= 1'b1;
    end
    else if (running)
      count <= count - 1;
  end

  // Idle output is the inverse of the initial level
  assign narrowTimerOutput = running ? initLevel : ~initLevel;
  assign narrowPinEnable   = pinEnReq;
endmodule : sbct_narrow_model

`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the sixteen-bit counter/timer
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk = 1'b0, srst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] registerPointer = 8'h0d, regWrData = 8'h00, regRdData, d, h, l;
  logic timerTick = 1'b1, pulseIn = 1'b0, nInit = 1'b0, pinEnReq = 1'b1;
  logic narrowTimerOutput, narrowTimeout, narrowPinEnable, narrowStart;
  logic timeoutIrq, captureIrq, port3Bit4Pin, port3Bit4Drive;
  logic port3Bit5Pin, port3Bit5Drive, port3Bit6Pin, port3Bit6Drive, a, b, e;
  logic [15:0] c2;
  int err_total = 0, checked = 0, cyc = 0, toCnt = 0, toLast = 0, toPrev = 0;
  int capCnt = 0, nsCnt = 0, n, t0, lat, tA, tB, tC;

  always #5 clk = ~clk;

  sbct_wide_timer u_sbct_wide_timer (.clk(clk), .srst(srst),
    .regAddr(regAddr), .registerPointer(registerPointer),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
    .regRdData(regRdData), .timerTick(timerTick), .pulseIn(pulseIn),
    .narrowTimerOutput(narrowTimerOutput), .narrowTimeout(narrowTimeout),
    .narrowPinEnable(narrowPinEnable), .narrowStart(narrowStart),
    .timeoutIrq(timeoutIrq), .captureIrq(captureIrq),
    .port3Bit4Pin(port3Bit4Pin), .port3Bit4Drive(port3Bit4Drive),
    .port3Bit5Pin(port3Bit5Pin), .port3Bit5Drive(port3Bit5Drive),
    .port3Bit6Pin(port3Bit6Pin), .port3Bit6Drive(port3Bit6Drive));

  sbct_narrow_model u_sbct_narrow_model (.clk(clk), .srst(srst),
    .narrowStart(narrowStart), .initLevel(nInit), .pinEnReq(pinEnReq),
    .narrowTimerOutput(narrowTimerOutput), .narrowTimeout(narrowTimeout),
    .narrowPinEnable(narrowPinEnable));

  ////////////////////////////////////////////////////////////////////////////
  // Cycle count and pulse monitors
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (timeoutIrq === 1'b1)
    begin
      toCnt  <= toCnt + 1;
      toPrev <= toLast;
      toLast <= cyc;
    end
    if (captureIrq === 1'b1) capCnt <= capCnt + 1;
    if (narrowStart === 1'b1) nsCnt <= nsCnt + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus cycles, waits and compares
  task automatic wrReg(input logic [3:0] ad, input logic [7:0] dt);
    @(posedge clk);
    regAddr   <= ad;
    regWrData <= dt;
    regWrite  <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wrReg

  task automatic rdReg(input logic [3:0] ad, output logic [7:0] dt);
    @(posedge clk);
    regAddr <= ad;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
    dt = regRdData;
  endtask : rdReg

  task automatic hold(input int k);
    repeat (k) @(posedge clk);
  endtask : hold

  task automatic chkReg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask : chkReg

  task automatic chkBit(input logic got, input logic exp);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
      err_total++;
    end
  endtask : chkBit

  task automatic chkNum(input logic signed [31:0] got, input int exp);
    checked++;
    if (got !== exp)
    begin
      $display("MISMATCH %0t count got %0d exp %0d", $time, got, exp);
      err_total++;
    end
  endtask : chkNum

  task automatic waitTo();
    int i;
    int n0;
    n0 = toCnt;
    for (i = 0; i < 300 && toCnt == n0; i++) @(posedge clk);
    chkBit(toCnt != n0, 1'b1);
  endtask : waitTo

  task automatic tally_and_finish();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hung wait
  initial
  begin
    #500000;
    err_total++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    hold(6);
    srst <= 1'b0;
    rdReg(sbct_pkg::OFF_CTRL2, d);
    chkReg(d, 8'h00);
    chkBit(port3Bit5Drive, 1'b0);
    registerPointer <= 8'h0c;
    wrReg(sbct_pkg::OFF_RLD_LO, 8'h5a);
    registerPointer <= 8'h0d;
    rdReg(sbct_pkg::OFF_RLD_LO, d);
    chkReg(d, sbct_pkg::BYTE_RESET);
    rdReg(4'hf, d);
    chkReg(d, 8'h00);
    wrReg(sbct_pkg::OFF_RLD_LO, 8'h5a);
    rdReg(sbct_pkg::OFF_RLD_LO, d);
    chkReg(d, 8'h5a);
    // Idle and forced output levels
    wrReg(sbct_pkg::OFF_CTRL2, 8'h01);
    hold(3);
    chkBit(port3Bit5Pin, 1'b1);
    chkBit(port3Bit5Drive, 1'b1);
    wrReg(sbct_pkg::OFF_CTRL1, 8'h01);
    hold(3);
    chkBit(port3Bit5Pin, 1'b0);
    wrReg(sbct_pkg::OFF_CTRL1, 8'h0d);
    hold(3);
    chkBit(port3Bit5Pin, 1'b1);
    wrReg(sbct_pkg::OFF_CTRL1, 8'h08);
    hold(3);
    chkBit(port3Bit5Pin, 1'b0);
    // Every logic combination on the shared pin
    for (int i = 0; i < 16; i++)
    begin
      nInit <= i[3];
      pinEnReq <= i[0];
      wrReg(sbct_pkg::OFF_CTRL1, {2'b01, i[1:0], 3'b000, i[2]});
      hold(3);
      a = ~i[2];
      b = ~i[3];
      e = (i[1:0] == 0) ? (a & b) : (i[1:0] == 1) ? (a | b) :
          (i[1:0] == 2) ? ~(a | b) : ~(a & b);
      chkBit(port3Bit6Pin, e);
      chkBit(port3Bit6Drive, 1'b1);
      chkBit(port3Bit4Pin, ~i[3]);
      chkBit(port3Bit4Drive, i[0]);
    end
    // One-shot timeout, output toggle and stop
    nInit <= 1'b0;
    wrReg(sbct_pkg::OFF_CTRL1, 8'h00);
    wrReg(sbct_pkg::OFF_RLD_LO, 8'h05);
    wrReg(sbct_pkg::OFF_RLD_HI, 8'h00);
    wrReg(sbct_pkg::OFF_CTRL2, 8'h83);
    t0 = cyc;
    hold(2);
    chkBit(port3Bit5Pin, 1'b0);
    waitTo();
    lat = toLast - t0 - 5;
    chkNum(lat, 1);
    hold(3);
    chkBit(port3Bit5Pin, 1'b1);
    rdReg(sbct_pkg::OFF_CTRL2, d);
    chkReg(d, 8'h23);
    hold(20);
    chkNum(toCnt, 1);
    // Counter holds while no tick arrives
    timerTick <= 1'b0;
    wrReg(sbct_pkg::OFF_CTRL2, 8'h83);
    t0 = cyc;
    hold(30);
    chkNum(toCnt, 1);
    timerTick <= 1'b1;
    waitTo();
    chkNum(toLast - t0, lat + 35);
    // Restart mid-count reloads the new initial value
    wrReg(sbct_pkg::OFF_RLD_LO, 8'h07);
    wrReg(sbct_pkg::OFF_CTRL2, 8'h83);
    hold(3);
    wrReg(sbct_pkg::OFF_CTRL2, 8'h03);
    wrReg(sbct_pkg::OFF_CTRL2, 8'h83);
    t0 = cyc;
    waitTo();
    chkNum(toLast - t0, lat + 7);
    // Auto-reload period and late reload write
    wrReg(sbct_pkg::OFF_RLD_LO, 8'h08);
    wrReg(sbct_pkg::OFF_CTRL2, 8'hc3);
    waitTo();
    waitTo();
    chkNum(toLast - toPrev, 8);
    wrReg(sbct_pkg::OFF_RLD_LO, 8'h05);
    waitTo();
    chkNum(toLast - toPrev, 8);
    waitTo();
    chkNum(toLast - toPrev, 5);
    wrReg(sbct_pkg::OFF_CTRL2, 8'h03);
    // Zero count wraps without a timeout
    wrReg(sbct_pkg::OFF_RLD_LO, 8'h00);
    n = toCnt;
    wrReg(sbct_pkg::OFF_CTRL2, 8'h83);
    hold(300);
    chkNum(toCnt, n);
    wrReg(sbct_pkg::OFF_CTRL2, 8'h00);
    // Demodulation edge selects
    wrReg(sbct_pkg::OFF_RLD_LO, 8'hff);
    wrReg(sbct_pkg::OFF_RLD_HI, 8'hff);
    for (int s = 1; s < 4; s++)
    begin
      wrReg(sbct_pkg::OFF_CTRL1, {2'b10, s[1:0], 4'h0});
      wrReg(sbct_pkg::OFF_CTRL2, 8'h84);
      n = capCnt;
      repeat (2)
      begin
        pulseIn <= 1'b1;
        hold(6);
        pulseIn <= 1'b0;
        hold(6);
      end
      chkNum(capCnt - n, (s == 3) ? 4 : 2);
      wrReg(sbct_pkg::OFF_CTRL2, 8'h00);
    end
    // Capture of complemented count between rising edges
    wrReg(sbct_pkg::OFF_CTRL1, 8'h90);
    wrReg(sbct_pkg::OFF_CTRL2, 8'h84);
    pulseIn <= 1'b1;
    tA = cyc;
    hold(4);
    pulseIn <= 1'b0;
    hold(12);
    pulseIn <= 1'b1;
    tB = cyc;
    hold(3);
    rdReg(sbct_pkg::OFF_CAP_HI, h);
    rdReg(sbct_pkg::OFF_CAP_LO, l);
    c2 = {h, l};
    pulseIn <= 1'b0;
    hold(20);
    pulseIn <= 1'b1;
    tC = cyc;
    hold(3);
    rdReg(sbct_pkg::OFF_CAP_HI, h);
    rdReg(sbct_pkg::OFF_CAP_LO, l);
    chkNum(c2, tB - tA - 1);
    chkNum({h, l} - c2, (tC - tB) - (tB - tA));
    rdReg(sbct_pkg::OFF_CTRL1, d);
    chkBit(d[0], 1'b1);
    wrReg(sbct_pkg::OFF_CTRL1, 8'h91);
    rdReg(sbct_pkg::OFF_CTRL1, d);
    chkBit(d[0], 1'b0);
    wrReg(sbct_pkg::OFF_CTRL2, 8'h00);
    // Ping-pong hand-over with the narrow timer
    wrReg(sbct_pkg::OFF_CTRL2, 8'h20);
    wrReg(sbct_pkg::OFF_CTRL1, 8'h04);
    wrReg(sbct_pkg::OFF_RLD_HI, 8'h00);
    wrReg(sbct_pkg::OFF_RLD_LO, 8'h05);
    n = toCnt;
    wrReg(sbct_pkg::OFF_CTRL2, 8'h83);
    waitTo();
    hold(2);
    rdReg(sbct_pkg::OFF_CTRL2, d);
    chkBit(d[7], 1'b0);
    chkBit(d[5], 1'b1);
    waitTo();
    chkNum(toCnt - n, 2);
    chkBit(nsCnt > 0, 1'b1);
    wrReg(sbct_pkg::OFF_CTRL1, 8'h00);
    wrReg(sbct_pkg::OFF_CTRL2, 8'h00);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
